/* rtl/i2ci_irq_dma.v */
// Notes on behaviour
// - Three sources: error, receive, transmit
// - Bus interrupts need global enable; flag events
// - Receive source: byte done, not sending
// - Receive DMA replaces receive interrupt with end-of-block
// - Transmit source: byte done while sending
// - Transmit DMA replaces transmit interrupt with end-of-block
// - Error source from event flag plus conditions
// - Vector: five programmed bits, three source bits
// - Three-bit level; all ones disables, zeros highest
// - Fixed order: error, receive, transmit
// - End-of-block shares priority of its direction
// - Pending set on event; request needs mask, level
// - Software clears pending; request holds meanwhile
// - Error pending forced while error flags set
// - Hold bit suspends DMA during error pending
// - DMA moves byte, increments address, decrements count
// - Limit 222 register file, 65535 memory
// - DMA requests carry the interrupt priority level
// - Receive and transmit DMA enabled independently
// - Count reaching zero sets end-of-block pending
// - End-of-block ignores global enable, no flag
// - Counter-pointer select bit picks register file
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "i2ci_map.vh"

module i2ci_irq_dma (
  input wire ref_clk,
  input wire rst_b,
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData_ff,
  input wire byteDone,
  input wire sendDir,
  input wire addrMatched,
  input wire ackEnable,
  input wire startSent,
  input wire ackFail,
  input wire stopDet,
  input wire arbLost,
  input wire busErr,
  input wire tenBitHdr,
  input wire addrSent,
  input wire sclEvent,
  input wire dmaAck,
  output reg eventFlag_ff,
  output reg irqReq_ff,
  output reg [7:0] irqVector_ff,
  output reg [2:0] irqLevel_ff,
  output reg dmaReq_ff,
  output reg dmaDirTx_ff,
  output reg [15:0] dmaAddr_ff,
  output reg dmaToRegfile_ff,
  output reg [2:0] dmaLevel_ff,
  output reg dmaDone_ff
);

  // Count limited when the register file is the target
  function [15:0] limCount;
    input [15:0] val;
    input rf;
    begin
      if (rf && (val > `I2CI_RF_MAX)) begin
        limCount = `I2CI_RF_MAX;
      end else begin
        limCount = val;
      end
    end
  endfunction

  // Next address: register file wraps in one byte
  function [15:0] incAddr;
    input [15:0] val;
    input rf;
    begin
      if (rf) begin
        incAddr = {8'h00, val[7:0] + 8'h01};
      end else begin
        incAddr = val + 16'h0001;
      end
    end
  endfunction

  reg rstSync1_ff;
  reg rstSync2_ff;
  wire rstN;

  reg [4:0] vecHi_ff;
  reg [1:0] dmaEn_ff;
  reg [1:0] eobPend_ff;
  reg errMask_ff;
  reg rxMask_ff;
  reg txMask_ff;
  reg holdOnErr_ff;
  reg [2:0] prl_ff;
  reg errPend_ff;
  reg rxPend_ff;
  reg txPend_ff;
  reg ite_ff;
  reg [7:0] cp_ff [0:1];
  reg [15:0] addr_ff [0:1];
  reg [15:0] cnt_ff [0:1];
  reg [1:0] reqPend_ff;
  reg byteDoneDly_ff;

  reg [1:0] nxt_dmaEn;
  reg [1:0] nxt_eobPend;
  reg [1:0] nxt_reqPend;
  reg nxt_errPend;
  reg nxt_rxPend;
  reg nxt_txPend;
  reg nxt_hold;
  reg nxt_dmaReq;
  reg nxt_dmaDirTx;
  reg [7:0] nxt_rdData;

  wire [15:0] nxt_addr [0:1];
  wire [15:0] nxt_cnt [0:1];
  wire [1:0] chByte;
  wire [1:0] chRf;
  wire [1:0] ackCh;
  wire [1:0] eobSet;
  wire [1:0] reqSet;

  // Reset release through two flip-flops
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end
  assign rstN = rstSync2_ff;

  // Write strobes per register
  wire wrVec = regWr && (regAddr == `I2CI_OFF_VEC);
  wire wrMask = regWr && (regAddr == `I2CI_OFF_MASK);
  wire wrPend = regWr && (regAddr == `I2CI_OFF_PEND);
  wire wrCtrl = regWr && (regAddr == `I2CI_OFF_CTRL);

  // Error conditions qualified by the event flag
  wire errFlags = tenBitHdr | addrMatched | startSent | sclEvent | addrSent |
    ackFail | stopDet | arbLost | busErr;
  wire anyEvent = errFlags | byteDone;
  wire errSrc = anyEvent & ((addrMatched & ackEnable) | startSent | ackFail |
    stopDet | arbLost | busErr | tenBitHdr | addrSent);
  wire errSet = ite_ff & (errSrc | errFlags);

  // One event per rising edge of byte done
  wire byteRise = byteDone & ~byteDoneDly_ff;
  assign chByte[0] = byteRise & ~sendDir;
  assign chByte[1] = byteRise & sendDir;

  // Data interrupts only without DMA in that direction
  wire rxSet = ite_ff & chByte[0] & ~dmaEn_ff[0];
  wire txSet = ite_ff & chByte[1] & ~dmaEn_ff[1];

  // Acknowledge counts only against a standing request
  wire ackHit = dmaAck & dmaReq_ff;

  // Per-direction DMA channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      wire [3:0] offAdL = (ch == 0) ? `I2CI_OFF_RXADL : `I2CI_OFF_TXADL;
      wire [3:0] offAdH = (ch == 0) ? `I2CI_OFF_RXADH : `I2CI_OFF_TXADH;
      wire [3:0] offCtL = (ch == 0) ? `I2CI_OFF_RXCTL : `I2CI_OFF_TXCTL;
      wire [3:0] offCtH = (ch == 0) ? `I2CI_OFF_RXCTH : `I2CI_OFF_TXCTH;
      wire [3:0] offCp = (ch == 0) ? `I2CI_OFF_RXCP : `I2CI_OFF_TXCP;
      wire [15:0] wrCnt;
      assign chRf[ch] = cp_ff[ch][`I2CI_CP_RFSEL];
      assign ackCh[ch] = ackHit & (dmaDirTx_ff == ch);
      assign eobSet[ch] = ackCh[ch] & (cnt_ff[ch] == 16'h0001);
      assign reqSet[ch] = chByte[ch] & dmaEn_ff[ch] &
        (cnt_ff[ch] != 16'h0000);
      assign wrCnt = (regAddr == offCtL) ? {cnt_ff[ch][15:8], regWrData} :
        {regWrData, cnt_ff[ch][7:0]};
      // Post increment and post decrement on each acknowledged byte
      assign nxt_addr[ch] = ackCh[ch] ? incAddr(addr_ff[ch], chRf[ch]) :
        (regWr && (regAddr == offAdL)) ? {addr_ff[ch][15:8], regWrData} :
        (regWr && (regAddr == offAdH)) ? {regWrData, addr_ff[ch][7:0]} :
        addr_ff[ch];
      assign nxt_cnt[ch] = ackCh[ch] ? cnt_ff[ch] - 16'h0001 :
        (regWr && ((regAddr == offCtL) || (regAddr == offCtH))) ?
        limCount(wrCnt, chRf[ch]) : cnt_ff[ch];

      // Channel state
      always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
          cp_ff[ch] <= `I2CI_RST_BYTE;
          addr_ff[ch] <= `I2CI_RST_WORD;
          cnt_ff[ch] <= `I2CI_RST_WORD;
        end else begin
          if (regWr && (regAddr == offCp)) begin
            cp_ff[ch] <= regWrData;
          end
          addr_ff[ch] <= nxt_addr[ch];
          cnt_ff[ch] <= nxt_cnt[ch];
        end
      end
    end
  endgenerate

  // Pending, enable and request next values; hardware set wins over clear
  always @* begin
    nxt_errPend = (wrPend ? regWrData[`I2CI_PND_ERR] : errPend_ff) |
      errSet;
    nxt_rxPend = (wrPend ? regWrData[`I2CI_PND_RX] : rxPend_ff) | rxSet;
    nxt_txPend = (wrPend ? regWrData[`I2CI_PND_TX] : txPend_ff) | txSet;
    nxt_hold = wrPend ? regWrData[`I2CI_PND_HOLD] : holdOnErr_ff;
    nxt_eobPend[0] = (wrMask ? regWrData[`I2CI_MSK_RXEOB] : eobPend_ff[0]) |
      eobSet[0];
    nxt_eobPend[1] = (wrMask ? regWrData[`I2CI_MSK_TXEOB] : eobPend_ff[1]) |
      eobSet[1];
    nxt_dmaEn[0] = (wrMask ? regWrData[`I2CI_MSK_RXDMA] : dmaEn_ff[0]) &
      ~eobSet[0];
    nxt_dmaEn[1] = (wrMask ? regWrData[`I2CI_MSK_TXDMA] : dmaEn_ff[1]) &
      ~eobSet[1];
    nxt_reqPend = (reqPend_ff & ~ackCh) | reqSet;
    // Receive channel served before transmit
    nxt_dmaDirTx = ~nxt_reqPend[0];
    nxt_dmaReq = (|nxt_reqPend) & ~(nxt_hold & nxt_errPend);
  end

  // Interrupt requests per source
  wire errReq = errPend_ff & errMask_ff;
  wire rxReq = (rxPend_ff | eobPend_ff[0]) & rxMask_ff;
  wire txReq = (txPend_ff | eobPend_ff[1]) & txMask_ff;
  wire levelOk = (prl_ff != `I2CI_PRL_OFF);
  // DMA outranks interrupts unless suspended
  wire irqAny = (errReq | rxReq | txReq) & levelOk & ~dmaReq_ff;

  // Source code in fixed internal order
  wire [2:0] srcCode = errReq ? `I2CI_VEC_ERR :
    rxReq ? `I2CI_VEC_RX :
    txReq ? `I2CI_VEC_TX : 3'h0;

  // Register read data, one cycle after the strobe
  always @* begin
    nxt_rdData = 8'h00;
    case (regAddr)
      `I2CI_OFF_VEC: nxt_rdData = {vecHi_ff, srcCode};
      `I2CI_OFF_MASK: nxt_rdData = {dmaEn_ff[0], dmaEn_ff[1], eobPend_ff[0],
        eobPend_ff[1], 1'b0, errMask_ff, rxMask_ff, txMask_ff};
      `I2CI_OFF_PEND: nxt_rdData = {holdOnErr_ff, prl_ff, 1'b0, errPend_ff,
        rxPend_ff, txPend_ff};
      `I2CI_OFF_RXCP: nxt_rdData = cp_ff[0];
      `I2CI_OFF_TXCP: nxt_rdData = cp_ff[1];
      `I2CI_OFF_CTRL: nxt_rdData = {eventFlag_ff, 6'h00, ite_ff};
      `I2CI_OFF_RXADL: nxt_rdData = addr_ff[0][7:0];
      `I2CI_OFF_RXADH: nxt_rdData = addr_ff[0][15:8];
      `I2CI_OFF_RXCTL: nxt_rdData = cnt_ff[0][7:0];
      `I2CI_OFF_RXCTH: nxt_rdData = cnt_ff[0][15:8];
      `I2CI_OFF_TXADL: nxt_rdData = addr_ff[1][7:0];
      `I2CI_OFF_TXADH: nxt_rdData = addr_ff[1][15:8];
      `I2CI_OFF_TXCTL: nxt_rdData = cnt_ff[1][7:0];
      `I2CI_OFF_TXCTH: nxt_rdData = cnt_ff[1][15:8];
      default: nxt_rdData = 8'h00;
    endcase
  end

  // Configuration, pending and output registers
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      vecHi_ff <= 5'h00;
      dmaEn_ff <= 2'h0;
      eobPend_ff <= 2'h0;
      errMask_ff <= 1'b0;
      rxMask_ff <= 1'b0;
      txMask_ff <= 1'b0;
      holdOnErr_ff <= `I2CI_RST_HOLD;
      prl_ff <= `I2CI_RST_PRL;
      errPend_ff <= 1'b0;
      rxPend_ff <= 1'b0;
      txPend_ff <= 1'b0;
      ite_ff <= 1'b0;
      reqPend_ff <= 2'h0;
      byteDoneDly_ff <= 1'b0;
      regRdData_ff <= 8'h00;
      eventFlag_ff <= 1'b0;
      irqReq_ff <= 1'b0;
      irqVector_ff <= 8'h00;
      irqLevel_ff <= `I2CI_RST_PRL;
      dmaReq_ff <= 1'b0;
      dmaDirTx_ff <= 1'b0;
      dmaAddr_ff <= `I2CI_RST_WORD;
      dmaToRegfile_ff <= 1'b0;
      dmaLevel_ff <= `I2CI_RST_PRL;
      dmaDone_ff <= 1'b0;
    end else begin
      if (wrVec) begin
        vecHi_ff <= regWrData[7:3];
      end
      if (wrMask) begin
        errMask_ff <= regWrData[`I2CI_MSK_ERR];
        rxMask_ff <= regWrData[`I2CI_MSK_RX];
        txMask_ff <= regWrData[`I2CI_MSK_TX];
      end
      if (wrPend) begin
        prl_ff <= regWrData[`I2CI_PND_PRL_HI:`I2CI_PND_PRL_LO];
      end
      if (wrCtrl) begin
        ite_ff <= regWrData[`I2CI_CTL_ITE];
      end
      dmaEn_ff <= nxt_dmaEn;
      eobPend_ff <= nxt_eobPend;
      holdOnErr_ff <= nxt_hold;
      errPend_ff <= nxt_errPend;
      rxPend_ff <= nxt_rxPend;
      txPend_ff <= nxt_txPend;
      reqPend_ff <= nxt_reqPend;
      byteDoneDly_ff <= byteDone;
      regRdData_ff <= regRd ? nxt_rdData : 8'h00;
      // End-of-block never reaches the event flag
      eventFlag_ff <= anyEvent;
      irqReq_ff <= irqAny;
      irqVector_ff <= {vecHi_ff, srcCode};
      irqLevel_ff <= prl_ff;
      dmaReq_ff <= nxt_dmaReq;
      dmaDirTx_ff <= nxt_dmaDirTx;
      dmaAddr_ff <= nxt_dmaDirTx ? nxt_addr[1] : nxt_addr[0];
      dmaToRegfile_ff <= nxt_dmaDirTx ? chRf[1] : chRf[0];
      dmaLevel_ff <= prl_ff;
      dmaDone_ff <= ackHit;
    end
  end

endmodule

/* rtl/i2ci_map.vh */
`ifndef I2CI_MAP_VH
`define I2CI_MAP_VH

// Register offsets on the plain register port
`define I2CI_OFF_VEC 4'h0
`define I2CI_OFF_MASK 4'h1
`define I2CI_OFF_PEND 4'h2
`define I2CI_OFF_RXCP 4'h3
`define I2CI_OFF_TXCP 4'h4
`define I2CI_OFF_CTRL 4'h5
`define I2CI_OFF_RXADL 4'h8
`define I2CI_OFF_RXADH 4'h9
`define I2CI_OFF_RXCTL 4'hA
`define I2CI_OFF_RXCTH 4'hB
`define I2CI_OFF_TXADL 4'hC
`define I2CI_OFF_TXADH 4'hD
`define I2CI_OFF_TXCTL 4'hE
`define I2CI_OFF_TXCTH 4'hF

// mask_register fields
`define I2CI_MSK_RXDMA 7
`define I2CI_MSK_TXDMA 6
`define I2CI_MSK_RXEOB 5
`define I2CI_MSK_TXEOB 4
`define I2CI_MSK_ERR 2
`define I2CI_MSK_RX 1
`define I2CI_MSK_TX 0

// pending_priority_register fields
`define I2CI_PND_HOLD 7
`define I2CI_PND_PRL_HI 6
`define I2CI_PND_PRL_LO 4
`define I2CI_PND_ERR 2
`define I2CI_PND_RX 1
`define I2CI_PND_TX 0

// control and counter-pointer fields
`define I2CI_CTL_ITE 0
`define I2CI_CTL_EVF 7
`define I2CI_CP_RFSEL 0

// Reset values
`define I2CI_RST_HOLD 1'b1
`define I2CI_RST_PRL 3'h7
`define I2CI_RST_BYTE 8'h00
`define I2CI_RST_WORD 16'h0000

// Vector low bits, disabled level, limits
`define I2CI_VEC_ERR 3'h2
`define I2CI_VEC_RX 3'h4
`define I2CI_VEC_TX 3'h6
`define I2CI_PRL_OFF 3'h7
`define I2CI_RF_MAX 16'h00DE

`endif

/* verification/i2ci_dma_partner.sv */
`timescale 1ns/100ps
// Arbiter side: takes each DMA request after a chosen wait
module i2ci_dma_partner (
  input logic ref_clk,
  input logic rst_b,
  input logic dmaReq_ff,
  input logic [3:0] waitCyc,
  output logic dmaAck_ff
);
  logic [3:0] cnt_ff;
  // One acknowledge pulse per request, never while idle
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 4'h0;
      dmaAck_ff <= 1'b0;
    end else if (dmaReq_ff && !dmaAck_ff && cnt_ff >= waitCyc) begin
      cnt_ff <= 4'h0;
      dmaAck_ff <= 1'b1;
    end else begin
      cnt_ff <= (dmaReq_ff && !dmaAck_ff) ? cnt_ff + 4'h1 : 4'h0;
      dmaAck_ff <= 1'b0;
    end
  end
endmodule

/* verification/i2ci_irq_dma_properties.sv */
`timescale 1ns/100ps
// Pin relations of the interrupt and DMA request block
module i2ci_irq_dma_properties (
  input logic ref_clk,
  input logic rst_b,
  input logic byteDone,
  input logic busErr,
  input logic dmaAck,
  input logic eventFlag_ff,
  input logic irqReq_ff,
  input logic [7:0] irqVector_ff,
  input logic [2:0] irqLevel_ff,
  input logic dmaReq_ff,
  input logic dmaToRegfile_ff,
  input logic [15:0] dmaAddr_ff,
  input logic [2:0] dmaLevel_ff,
  input logic dmaDone_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // A request taken by the arbiter
  sequence s_take;
    dmaReq_ff && dmaAck;
  endsequence
  a_flag_mirror: assert property ((byteDone || busErr) |=> eventFlag_ff)
    else $error("event flag missing");
  a_vector_code: assert property (irqReq_ff |-> irqVector_ff[2:0] inside {3'h2, 3'h4, 3'h6})
    else $error("bad vector code");
  a_level_same: assert property (irqLevel_ff == dmaLevel_ff)
    else $error("dma level differs");
  a_level_off: assert property (irqLevel_ff == 3'h7 && $past(irqLevel_ff) == 3'h7 |-> !irqReq_ff)
    else $error("request at disabled level");
  a_dma_first: assert property (dmaReq_ff && $past(dmaReq_ff) |-> !irqReq_ff)
    else $error("interrupt beside dma");
  a_done_after: assert property (s_take |=> dmaDone_ff)
    else $error("no done after ack");
  a_done_cause: assert property (dmaDone_ff |-> $past(dmaReq_ff) && $past(dmaAck))
    else $error("done without ack");
  a_rf_page: assert property (dmaReq_ff && dmaToRegfile_ff |-> dmaAddr_ff[15:8] == 8'h00)
    else $error("regfile address high");
  cover property (s_take);
endmodule

bind i2ci_irq_dma i2ci_irq_dma_properties u_props (.*);

/* verification/i2ci_irq_dma_tb.sv */
`timescale 1ns/100ps
`include "i2ci_map.vh"
// Self-checking bench for the interrupt and DMA request block
module i2ci_irq_dma_tb;
  localparam logic [3:0] PND = `I2CI_OFF_PEND;
  localparam logic [3:0] MSK = `I2CI_OFF_MASK;
  logic ref_clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic byteDone = 1'b0, sendDir = 1'b0, ackEnable = 1'b1, dmaAck;
  logic [3:0] regAddr = 4'h0, waitCyc = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData_ff, irqVector_ff;
  logic [8:0] fl = 9'h000, irqOld = 9'h000;
  logic eventFlag_ff, irqReq_ff, dmaReq_ff, dmaDirTx_ff, dmaToRegfile_ff, dmaDone_ff;
  logic [2:0] irqLevel_ff, dmaLevel_ff;
  logic [15:0] dmaAddr_ff, adr;
  logic [7:0] rdQ[$], irqQ[$];
  logic [17:0] dmaQ[$];
  logic rdPend = 1'b0, dmaOld = 1'b0;
  logic [4:0] vh;
  int err_total = 0, cmp_count = 0, seed = 53, cyc = 0;

  i2ci_irq_dma DUT (.*, .addrMatched(fl[0]), .startSent(fl[1]), .ackFail(fl[2]),
    .stopDet(fl[3]), .arbLost(fl[4]), .busErr(fl[5]), .tenBitHdr(fl[6]),
    .addrSent(fl[7]), .sclEvent(fl[8]));
  i2ci_dma_partner u_arb (.*, .dmaAck_ff(dmaAck));

  always #10 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    w(1);
    regWr <= 1'b0;
    w(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    regAddr <= a;
    regRd <= 1'b1;
    w(1);
    regRd <= 1'b0;
    w(1);
  endtask
  task automatic ev(input logic dir);
    sendDir <= dir;
    byteDone <= 1'b1;
    w(1);
    byteDone <= 1'b0;
    w(1);
  endtask
  task automatic flag(input int i);
    fl[i] <= 1'b1;
    w(1);
    fl[i] <= 1'b0;
  endtask
  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      end_of_test();
    end
  end

  // Takes the oldest note whenever a result shows
  always @(posedge ref_clk) begin
    rdPend <= regRd;
    dmaOld <= dmaReq_ff;
    irqOld <= {irqReq_ff, irqVector_ff};
    if (rdPend) chk("read", rdQ.pop_front(), regRdData_ff);
    if (dmaReq_ff && !dmaOld) chk("dma", dmaQ.pop_front(), {dmaDirTx_ff, dmaToRegfile_ff, dmaAddr_ff});
    if (irqReq_ff && {irqReq_ff, irqVector_ff} !== irqOld) chk("vector", irqQ.pop_front(), irqVector_ff);
  end

  // Main sequence
  initial begin
    vh = 5'($random(seed));
    adr = 16'($random(seed));
    w(12);
    rst_b <= 1'b1;
    w(3);
    rd(PND, 8'hF0);
    rd(MSK, 8'h00);
    rd(4'h6, 8'h00);
    ev(1'b0);
    rd(PND, 8'hF0);
    wr(`I2CI_OFF_CTRL, 8'h01);
    wr(`I2CI_OFF_VEC, {vh, 3'h0});
    wr(PND, 8'hB0);
    for (int i = 0; i < 9; i++) begin
      flag(i);
      rd(PND, 8'hB4);
      wr(PND, 8'hB0);
    end
    chk("level", 18'h0001B, {irqLevel_ff, dmaLevel_ff});
    // Receive and transmit pending, then error, in fixed order
    wr(MSK, 8'h07);
    irqQ.push_back({vh, `I2CI_VEC_RX});
    ev(1'b0);
    ev(1'b1);
    rd(PND, 8'hB3);
    w(8);
    rd(`I2CI_OFF_VEC, {vh, `I2CI_VEC_RX});
    irqQ.push_back({vh, `I2CI_VEC_TX});
    wr(PND, 8'hB1);
    irqQ.push_back({vh, `I2CI_VEC_ERR});
    flag(5);
    w(3);
    irqQ.push_back({vh, `I2CI_VEC_TX});
    wr(PND, 8'hB1);
    wr(PND, 8'hF1);
    w(3);
    chk("irq off", 1'b0, irqReq_ff);
    irqQ.push_back({vh, `I2CI_VEC_TX});
    wr(PND, 8'h81);
    w(3);
    wr(PND, 8'hB0);
    // Receive DMA into memory; end of block after global enable is dropped
    wr(`I2CI_OFF_RXADL, adr[7:0]);
    wr(`I2CI_OFF_RXADH, adr[15:8]);
    wr(`I2CI_OFF_RXCTL, 8'h02);
    wr(MSK, 8'h87);
    waitCyc <= 4'h6;
    dmaQ.push_back({2'b00, adr});
    dmaQ.push_back({2'b00, adr + 16'h0001});
    irqQ.push_back({vh, `I2CI_VEC_RX});
    ev(1'b0);
    w(10);
    ev(1'b0);
    wr(`I2CI_OFF_CTRL, 8'h00);
    w(10);
    rd(MSK, 8'h27);
    rd(PND, 8'hB0);
    // Transmit DMA to the register file, held while an error is pending
    wr(MSK, 8'h07);
    wr(`I2CI_OFF_CTRL, 8'h01);
    wr(`I2CI_OFF_TXCP, 8'h01);
    wr(`I2CI_OFF_TXCTL, 8'hFF);
    rd(`I2CI_OFF_TXCTL, 8'hDE);
    wr(`I2CI_OFF_TXCTL, 8'h01);
    wr(`I2CI_OFF_TXADL, adr[7:0]);
    wr(MSK, 8'h47);
    waitCyc <= 4'h0;
    irqQ.push_back({vh, `I2CI_VEC_ERR});
    flag(5);
    ev(1'b1);
    w(6);
    chk("dma held", 1'b0, dmaReq_ff);
    dmaQ.push_back({2'b11, 8'h00, adr[7:0]});
    irqQ.push_back({vh, `I2CI_VEC_TX});
    wr(PND, 8'hB0);
    w(10);
    rd(MSK, 8'h17);
    // Let the last read land, then every note must have been used
    w(2);
    chk("left", 18'h00000, 18'(rdQ.size() + irqQ.size() + dmaQ.size()));
    end_of_test();
  end
endmodule
